// *** bench/tb_top.sv ***
// self-checking bench for the pll and distribution configuration block
// assumes pdc_top with axi4-lite on aclk; assertions live in the design
`timescale 1ns/1ns
module tb_top
  import pdc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] prot = 3'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic ref_div_in = 0, fb_div_in = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pll_pd, div_bypass, src_vco, cp_up, cp_dn, cp_hiz;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [2:0] cp_current;
  logic [7:0] a_pc = PLL_CTRL_RST, a_rt = ROUTE_RST, a_cu = CP_CUR_RST;
  logic [9:0] ridx [4] = '{IDX_PLL_CTRL, IDX_ABL, IDX_ROUTE, IDX_CP_CUR};
  logic [7:0] rval [4] = '{PLL_CTRL_RST, ABL_RST, ROUTE_RST, CP_CUR_RST};
  logic [2:0] cmode [5] = '{CPM_HIZ, CPM_UP, CPM_DOWN, 3'h5, CPM_UP};
  logic [2:0] cexp [5] = '{3'h4, 3'h2, 3'h1, 3'h4, 3'h4};
  int n_mismatch = 0, n_compared = 0, cyc = 0, ov = 0;
  int seed = 32'hca978836;

  pdc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(prot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(prot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ref_div_in(ref_div_in),
    .fb_div_in(fb_div_in), .pll_pd(pll_pd), .div_bypass(div_bypass), .src_vco(src_vco),
    .cp_up(cp_up), .cp_dn(cp_dn), .cp_hiz(cp_hiz), .cp_current(cp_current));

  always #25 aclk = ~aclk;

  // ==========================================================
  // reporting
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ==========================================================
  // axi4-lite master
  task automatic wr(input logic [9:0] idx, input logic [7:0] dat, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] dat, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // ==========================================================
  // expectations and configuration
  function automatic logic [5:0] exp_out(logic [7:0] pc, logic [7:0] rt, logic [7:0] cu);
    return {pc[1:0] != PWR_NORMAL, rt[BYP_BIT], rt[SRC_BIT], cu[2:0]};
  endfunction

  task automatic cfg(input logic [7:0] pc, ab, rt, cu, upd);
    wr(IDX_PLL_CTRL, pc, r);
    chk("bresp", r, RESP_OKAY);
    wr(IDX_ABL, ab, r);
    wr(IDX_ROUTE, rt, r);
    wr(IDX_CP_CUR, cu, r);
    chk("held", {pll_pd, div_bypass, src_vco, cp_current}, exp_out(a_pc, a_rt, a_cu));
    wr(IDX_UPDATE, upd, r);
    if (upd === UPDATE_GO) begin
      a_pc = pc;
      a_rt = rt;
      a_cu = cu;
    end
    chk("cfg", {pll_pd, div_bypass, src_vco, cp_current}, exp_out(a_pc, a_rt, a_cu));
    rd(IDX_UPDATE, d, r);
    chk("upd_clear", d, 32'h0);
    rd(IDX_PLL_CTRL, d, r);
    chk("pending", d, {24'h0, pc});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("rst_out", {cp_hiz, pll_pd, div_bypass, src_vco, cp_current}, {1'b1, exp_out(a_pc, a_rt, a_cu)});
    for (int i = 0; i < 4; i++) begin
      rd(ridx[i], d, r);
      chk("rst_reg", d, {24'h0, rval[i]});
    end
    wr(10'h3FF, 8'h5A, r);
    chk("unmapped_b", r, RESP_SLVERR);
    rd(10'h3FF, d, r);
    chk("unmapped_rresp", r, RESP_SLVERR);
    chk("unmapped_r", d, 32'h0);
    wr(IDX_STATUS, 8'hFF, r);
    chk("status_b", r, RESP_OKAY);
    // every route code, pll on and off, then a refused commit
    for (int i = 0; i < 8; i++) begin
      cfg({6'h0, i[0], 1'b0}, 8'h0, {6'h0, i[2:1]}, {5'h0, i[2:0]}, UPDATE_GO);
    end
    cfg(8'h00, 8'h00, 8'h03, 8'h02, 8'h02);
    s_axi_wstrb <= 4'hE;
    wr(IDX_UPDATE, UPDATE_GO, r);
    s_axi_wstrb <= 4'hF;
    chk("strb_off", {pll_pd, div_bypass, src_vco, cp_current}, exp_out(a_pc, a_rt, a_cu));
    for (int i = 0; i < 20; i++) begin
      cfg(8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 8'($random(seed)), (i % 4 == 3) ? 8'h00 : UPDATE_GO);
    end
    // fixed pump modes, last one with the pll powered down
    for (int i = 0; i < 5; i++) begin
      cfg({1'b0, cmode[i], 2'b00, 1'b0, i == 4}, 8'h0, 8'h0, 8'h7, UPDATE_GO);
      repeat (2) @(posedge aclk);
      chk("cp_mode", {cp_hiz, cp_up, cp_dn}, cexp[i]);
      rd(IDX_STATUS, d, r);
      chk("status", d, {26'h0, cexp[i][2], cexp[i][0], cexp[i][1], 2'b00, i == 4});
    end
    // phase detection with both polarities and every overlap width
    for (int i = 0; i < 8; i++) begin
      cfg({i[2], CPM_NORMAL, 2'b00, PWR_NORMAL}, {6'h0, i[1:0]}, 8'h0, 8'h7, UPDATE_GO);
      ref_div_in <= 1'b1;
      repeat (8) @(posedge aclk);
      chk("cp_ref", {cp_hiz, cp_up, cp_dn}, i[2] ? 3'h1 : 3'h2);
      fb_div_in <= 1'b1;
      ov = 0;
      repeat (14) begin
        @(posedge aclk);
        ov += int'(cp_up === 1'b1 && cp_dn === 1'b1);
      end
      chk("overlap", ov, i[1:0] + 1);
      chk("cp_clear", {cp_up, cp_dn}, 2'h0);
      ref_div_in <= 1'b0;
      fb_div_in <= 1'b0;
      repeat (14) @(posedge aclk);
    end
    stop_test();
  end
endmodule

// *** inc/pdc_pfd_if.sv ***
// signals between the register block and the phase detector
// assumes both ends run on aclk
`timescale 1ns/1ns
interface pdc_pfd_if;
  logic pll_run;
  logic pol_neg;
  logic [2:0] cp_mode;
  logic [1:0] abl_sel;
  logic ref_in;
  logic fb_in;
  logic cp_up;
  logic cp_dn;
  logic cp_hiz;
  modport ctl(output pll_run, pol_neg, cp_mode, abl_sel, ref_in, fb_in, input cp_up, cp_dn, cp_hiz);
  modport pfd(input pll_run, pol_neg, cp_mode, abl_sel, ref_in, fb_in, output cp_up, cp_dn, cp_hiz);
endinterface

// *** inc/pdc_pkg.sv ***
// constants and types of the pll and distribution configuration block
// assumes a 32-bit axi4-lite master and a 20 MHz aclk
package pdc_pkg;
  // ==========================================================
  // register indices; byte address is four times the index
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_PLL_CTRL = 10'h010;
  localparam logic [IDX_W-1:0] IDX_ABL = 10'h017;
  localparam logic [IDX_W-1:0] IDX_ROUTE = 10'h1E1;
  localparam logic [IDX_W-1:0] IDX_UPDATE = 10'h232;
  localparam logic [IDX_W-1:0] IDX_CP_CUR = 10'h0F0;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0F1;
  localparam int ADDR_W = 12;
  // ==========================================================
  // field positions
  localparam int PWR_LSB = 0;
  localparam int CPM_LSB = 4;
  localparam int POL_BIT = 7;
  localparam int BYP_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam int ABL_LSB = 0;
  localparam int CUR_LSB = 0;
  // ==========================================================
  // field codes
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_ASYNC_PD = 2'h1;
  localparam logic [2:0] CPM_HIZ = 3'h0;
  localparam logic [2:0] CPM_UP = 3'h1;
  localparam logic [2:0] CPM_DOWN = 3'h2;
  localparam logic [2:0] CPM_NORMAL = 3'h3;
  localparam logic [7:0] UPDATE_GO = 8'h01;
  // ==========================================================
  // reset values: pll off, vco divider used, external clock
  localparam logic [7:0] PLL_CTRL_RST = 8'h01;
  localparam logic [7:0] ABL_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] CP_CUR_RST = 8'h07;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [7:0] pll_ctrl;
    logic [7:0] abl;
    logic [7:0] route;
    logic [7:0] cp_cur;
  } pdc_cfg_t;
  localparam pdc_cfg_t CFG_RST = '{PLL_CTRL_RST, ABL_RST, ROUTE_RST, CP_CUR_RST};
endpackage

// *** src/pdc_pfd.sv ***
// phase detector and charge pump steering
// assumes ref_in and fb_in are asynchronous divider outputs
`timescale 1ns/1ns
module pdc_pfd
  import pdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  pdc_pfd_if.pfd lp
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
    logic up;
    logic dn;
    logic [2:0] abl;
    logic cp_up;
    logic cp_dn;
    logic cp_hiz;
  } pdc_pfd_st_t;
  localparam pdc_pfd_st_t ST_RST = '{default: '0, cp_hiz: 1'b1};
  pdc_pfd_st_t q;
  pdc_pfd_st_t n;
  logic [1:0] edg;
  logic pu;
  logic pd;
  // ==========================================================
  // next state
  always_comb begin
    n = q;
    n.s1 = {lp.fb_in, lp.ref_in};
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < 2; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.lvl[i] = q.s3[i];
      end
    end
    edg = n.lvl & ~q.lvl;
    if (!lp.pll_run) begin
      n.up = 1'b0;
      n.dn = 1'b0;
      n.abl = '0;
    end else begin
      if (edg[0]) begin
        n.up = 1'b1;
      end
      if (edg[1]) begin
        n.dn = 1'b1;
      end
      if (q.up && q.dn) begin
        if (q.abl == {1'b0, lp.abl_sel}) begin
          n.up = edg[0];
          n.dn = edg[1];
          n.abl = '0;
        end else begin
          n.abl = q.abl + 3'h1;
        end
      end
    end
    pu = lp.pol_neg ? n.dn : n.up;
    pd = lp.pol_neg ? n.up : n.dn;
    case (lp.cp_mode)
      CPM_NORMAL: begin
        n.cp_up = pu;
        n.cp_dn = pd;
        n.cp_hiz = 1'b0;
      end
      CPM_UP: begin
        n.cp_up = 1'b1;
        n.cp_dn = 1'b0;
        n.cp_hiz = 1'b0;
      end
      CPM_DOWN: begin
        n.cp_up = 1'b0;
        n.cp_dn = 1'b1;
        n.cp_hiz = 1'b0;
      end
      default: begin
        n.cp_up = 1'b0;
        n.cp_dn = 1'b0;
        n.cp_hiz = 1'b1;
      end
    endcase
    if (!lp.pll_run) begin
      n.cp_up = 1'b0;
      n.cp_dn = 1'b0;
      n.cp_hiz = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end
  assign lp.cp_up = q.cp_up;
  assign lp.cp_dn = q.cp_dn;
  assign lp.cp_hiz = q.cp_hiz;
  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ref_lead_up_a: assert property (lp.pll_run && lp.cp_mode == CPM_NORMAL && !lp.pol_neg
    && edg == 2'h1 && !q.dn |=> lp.cp_up && !lp.cp_dn) else $error("ref edge did not pump up");
  pol_invert_a: assert property (lp.pll_run && lp.cp_mode == CPM_NORMAL && lp.pol_neg
    && edg == 2'h1 && !q.dn |=> lp.cp_dn && !lp.cp_up) else $error("negative polarity not inverted");
  const_mode_a: assert property (lp.pll_run && lp.cp_mode == CPM_UP |=> lp.cp_up && !lp.cp_dn)
    else $error("constant pump up missing");
  hiz_mode_a: assert property (lp.cp_mode == CPM_HIZ |=> lp.cp_hiz && !lp.cp_up && !lp.cp_dn)
    else $error("hiz mode still pumping");
  abl_width_a: assert property (q.up && q.dn |-> q.abl <= {1'b0, lp.abl_sel})
    else $error("antibacklash overlap too long");
  abl_end_a: assert property (q.up && q.dn && q.abl == {1'b0, lp.abl_sel} && edg == 2'h0
    && lp.pll_run |=> !q.up && !q.dn) else $error("antibacklash did not end");
  pd_quiet_a: assert property (!lp.pll_run [*2] |-> !q.up && !q.dn && lp.cp_hiz)
    else $error("pumping while powered down");
  pump_up_c: cover property (lp.cp_mode == CPM_NORMAL && lp.cp_up ##1 lp.cp_up && lp.cp_dn);
endmodule

// *** src/pdc_top.sv ***
// pll power, charge pump and distribution routing configuration
// assumes an axi4-lite master on aclk and async divider pins
//
// Overview of operation
// - power field 01 powers pll down
// - power field 00 runs pll normally
// - bypass bit set skips the vco divider
// - source bit clear selects external clock
// - polarity bit inverts pump up and down in normal mode only
// - settings apply only after update write 0x01
// - two-bit field sets antibacklash overlap width
// - mode field: hiz, up, down, normal
// - eight step charge pump current select
// - detector compares r and n edges
// - source bit set selects internal vco
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module pdc_top
  import pdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ref_div_in,
  input wire logic fb_div_in,
  output logic pll_pd,
  output logic div_bypass,
  output logic src_vco,
  output logic cp_up,
  output logic cp_dn,
  output logic cp_hiz,
  output logic [2:0] cp_current
);
  typedef struct packed {
    logic aw_ok;
    logic [IDX_W-1:0] aw_idx;
    logic w_ok;
    logic [7:0] w_dat;
    logic w_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    pdc_cfg_t pend;
    pdc_cfg_t act;
  } pdc_top_st_t;
  localparam pdc_top_st_t ST_RST = '{
    aw_ok: 1'b0,
    aw_idx: '0,
    w_ok: 1'b0,
    w_dat: '0,
    w_en: 1'b0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    rvalid: 1'b0,
    rdata: '0,
    rresp: RESP_OKAY,
    pend: CFG_RST,
    act: CFG_RST
  };
  pdc_top_st_t q;
  pdc_top_st_t n;
  logic have_aw;
  logic have_w;
  logic do_wr;
  logic do_upd;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0] wr_dat;
  logic wr_en;
  logic do_rd;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] status;
  logic wr_mapped;
  logic rd_mapped;
  pdc_pfd_if pl();
  // ==========================================================
  // active configuration to the outside
  assign pll_pd = q.act.pll_ctrl[PWR_LSB +: 2] != PWR_NORMAL;
  assign div_bypass = q.act.route[BYP_BIT];
  assign src_vco = q.act.route[SRC_BIT];
  assign cp_current = q.act.cp_cur[CUR_LSB +: 3];
  assign pl.pll_run = q.act.pll_ctrl[PWR_LSB +: 2] == PWR_NORMAL;
  assign pl.pol_neg = q.act.pll_ctrl[POL_BIT];
  assign pl.cp_mode = q.act.pll_ctrl[CPM_LSB +: 3];
  assign pl.abl_sel = q.act.abl[ABL_LSB +: 2];
  assign pl.ref_in = ref_div_in;
  assign pl.fb_in = fb_div_in;
  assign cp_up = pl.cp_up;
  assign cp_dn = pl.cp_dn;
  assign cp_hiz = pl.cp_hiz;
  assign status = {2'h0, pl.cp_hiz, pl.cp_dn, pl.cp_up, src_vco, div_bypass, pll_pd};
  // ==========================================================
  // phase detector
  pdc_pfd u_pfd (
    .aclk(aclk),
    .aresetn(aresetn),
    .lp(pl)
  );
  // ==========================================================
  // axi handshakes
  assign s_axi_awready = !q.aw_ok && !q.bvalid;
  assign s_axi_wready = !q.w_ok && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign have_aw = q.aw_ok || (s_axi_awvalid && s_axi_awready);
  assign have_w = q.w_ok || (s_axi_wvalid && s_axi_wready);
  assign do_wr = have_aw && have_w;
  assign wr_idx = q.aw_ok ? q.aw_idx : s_axi_awaddr[ADDR_W-1:2];
  assign wr_dat = q.w_ok ? q.w_dat : s_axi_wdata[7:0];
  assign wr_en = q.w_ok ? q.w_en : s_axi_wstrb[0];
  assign do_upd = do_wr && wr_en && wr_idx == IDX_UPDATE && wr_dat == UPDATE_GO;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  // ==========================================================
  // next state
  always_comb begin
    n = q;
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_ok = 1'b1;
      n.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_ok = 1'b1;
      n.w_dat = s_axi_wdata[7:0];
      n.w_en = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (do_wr) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (wr_idx)
        IDX_PLL_CTRL: begin
          if (wr_en) begin
            n.pend.pll_ctrl = wr_dat;
          end
        end
        IDX_ABL: begin
          if (wr_en) begin
            n.pend.abl = wr_dat;
          end
        end
        IDX_ROUTE: begin
          if (wr_en) begin
            n.pend.route = wr_dat;
          end
        end
        IDX_CP_CUR: begin
          if (wr_en) begin
            n.pend.cp_cur = wr_dat;
          end
        end
        IDX_UPDATE: begin
          if (do_upd) begin
            n.act = q.pend;
          end
        end
        IDX_STATUS: begin
          n.bresp = RESP_OKAY;
        end
        default: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (do_rd) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (rd_idx)
        IDX_PLL_CTRL: begin
          n.rdata = q.pend.pll_ctrl;
        end
        IDX_ABL: begin
          n.rdata = q.pend.abl;
        end
        IDX_ROUTE: begin
          n.rdata = q.pend.route;
        end
        IDX_CP_CUR: begin
          n.rdata = q.pend.cp_cur;
        end
        IDX_UPDATE: begin
          n.rdata = 8'h00;
        end
        IDX_STATUS: begin
          n.rdata = status;
        end
        default: begin
          n.rdata = 8'h00;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  upd_commit_a: assert property (do_upd |=> q.act == $past(q.pend))
    else $error("update did not commit pending values");
  act_hold_a: assert property (!do_upd |=> $stable(q.act))
    else $error("active values changed without update");
  pll_off_a: assert property (pll_pd [*3] |-> cp_hiz && !cp_up && !cp_dn)
    else $error("pumping while pll powered down");
  bypass_a: assert property (do_upd |=> div_bypass == $past(q.pend.route[BYP_BIT]))
    else $error("bypass not taken from commit");
  src_sel_a: assert property (do_upd |=> src_vco == $past(q.pend.route[SRC_BIT]))
    else $error("source select not taken from commit");
  cur_sel_a: assert property (do_upd |=> cp_current == $past(q.pend.cp_cur[CUR_LSB +: 3]))
    else $error("current select not committed");
  upd_reads_zero_a: assert property (do_rd && rd_idx == IDX_UPDATE |=> s_axi_rdata == 32'h00000000)
    else $error("update register did not read zero");
  run_mode_a: assert property (do_upd && q.pend.pll_ctrl[PWR_LSB +: 2] == PWR_NORMAL
    |=> !pll_pd && pl.pll_run) else $error("pll not running after commit");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  // ==========================================================
  // register store and answer checks
  assign wr_mapped = wr_idx inside {IDX_PLL_CTRL, IDX_ABL, IDX_ROUTE, IDX_CP_CUR, IDX_UPDATE, IDX_STATUS};
  assign rd_mapped = rd_idx inside {IDX_PLL_CTRL, IDX_ABL, IDX_ROUTE, IDX_CP_CUR, IDX_UPDATE, IDX_STATUS};
  wr_pll_a: assert property (do_wr && wr_en && wr_idx == IDX_PLL_CTRL |=> q.pend.pll_ctrl == $past(wr_dat))
    else $error("pll control write not kept pending");
  wr_abl_a: assert property (do_wr && wr_en && wr_idx == IDX_ABL |=> q.pend.abl == $past(wr_dat))
    else $error("antibacklash write not kept pending");
  wr_route_a: assert property (do_wr && wr_en && wr_idx == IDX_ROUTE |=> q.pend.route == $past(wr_dat))
    else $error("routing write not kept pending");
  wr_cur_a: assert property (do_wr && wr_en && wr_idx == IDX_CP_CUR |=> q.pend.cp_cur == $past(wr_dat))
    else $error("current write not kept pending");
  wr_skip_a: assert property (do_wr && !wr_en |=> $stable(q.pend) && $stable(q.act))
    else $error("write without strobe changed state");
  pd_commit_a: assert property (do_upd && q.pend.pll_ctrl[PWR_LSB +: 2] == PWR_ASYNC_PD
    |=> pll_pd && !pl.pll_run) else $error("pll not powered down after commit");
  pol_commit_a: assert property (do_upd |=> pl.pol_neg == $past(q.pend.pll_ctrl[POL_BIT]))
    else $error("polarity not committed");
  mode_commit_a: assert property (do_upd |=> pl.cp_mode == $past(q.pend.pll_ctrl[CPM_LSB +: 3]))
    else $error("pump mode not committed");
  abl_commit_a: assert property (do_upd |=> pl.abl_sel == $past(q.pend.abl[ABL_LSB +: 2]))
    else $error("antibacklash select not committed");
  upd_no_go_a: assert property (do_wr && wr_idx == IDX_UPDATE && !do_upd |=> $stable(q.act))
    else $error("commit without go code");
  rd_pend_a: assert property (do_rd && rd_idx == IDX_PLL_CTRL |=> s_axi_rdata[7:0] == $past(q.pend.pll_ctrl))
    else $error("pll control read not pending value");
  status_rd_a: assert property (do_rd && rd_idx == IDX_STATUS |=> s_axi_rdata[7:0] == $past(status))
    else $error("status read wrong");
  wr_answer_a: assert property (do_wr |=> s_axi_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (do_rd |=> s_axi_rvalid)
    else $error("read not answered");
  unmapped_wr_a: assert property (do_wr && !wr_mapped |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  mapped_wr_a: assert property (do_wr && wr_mapped |=> s_axi_bresp == RESP_OKAY)
    else $error("mapped write refused");
  unmapped_rd_a: assert property (do_rd && !rd_mapped |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  mapped_rd_a: assert property (do_rd && rd_mapped |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  b_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not cleared");
  r_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not cleared");
  commit_c: cover property (do_upd);
  status_rd_c: cover property (do_rd && rd_idx == IDX_STATUS);
  bypass_on_c: cover property (div_bypass && !pll_pd);
  unmapped_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
